// *** sdcs_pkg.sv ***
package sdcs_pkg;

	// data path sizes
	localparam int COL_W = 10;
	localparam int DQ_W = 16;
	localparam int BEAT_W = 4;

	// largest burst and latency the pipeline is sized for
	localparam int MAX_BL = 8;
	localparam int MAX_CL = 3;

	// default burst length and read latency in clocks
	localparam int BL_DEFAULT = 4;
	localparam int CL_DEFAULT = 2;

	// reset values of the state register and the column and beat step sizes
	localparam logic CKE_RESET = 1'h0;
	localparam logic HELD_RESET = 1'h1;
	localparam logic [COL_W-1:0] COL_RESET = 10'h000;
	localparam logic [DQ_W-1:0] DQ_RESET = 16'h0000;
	localparam logic [BEAT_W-1:0] BEAT_RESET = 4'h0;
	localparam logic [BEAT_W-1:0] BEAT_ONE = 4'h1;
	localparam logic [COL_W-1:0] COL_STEP = 10'h001;

	// decoded command on the control pins
	typedef enum logic [2:0] {
		CMD_INHIBIT = 3'h0,
		CMD_NOP = 3'h1,
		CMD_READ = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_OTHER = 3'h4
	} sdcs_cmd_t;

	// operating mode of the clock gate
	typedef enum logic [1:0] {
		MODE_RUN = 2'h0,
		MODE_SUSPEND = 2'h1,
		MODE_POWERDOWN = 2'h2
	} sdcs_mode_t;

	// active-low command strobes as they arrive on the pins
	typedef struct packed {
		logic chipSelN;
		logic rowStrobeN;
		logic colStrobeN;
		logic writeEnN;
	} sdcs_pins_t;

	// one entry of the read latency pipeline
	typedef struct packed {
		logic valid;
		logic [COL_W-1:0] col;
	} sdcs_slot_t;

	// write port toward the storage array
	typedef struct packed {
		logic en;
		logic [COL_W-1:0] col;
		logic [DQ_W-1:0] data;
	} sdcs_wr_t;

	// complete state of the clock suspend block
	typedef struct packed {
		sdcs_mode_t mode;
		logic ckeSample;
		logic clkHeld;
		logic burstActive;
		logic burstWrite;
		logic [COL_W-1:0] burstCol;
		logic [BEAT_W-1:0] beatsLeft;
		sdcs_slot_t [MAX_CL-1:0] pipe;
		logic [DQ_W-1:0] dqOut;
		logic dqOe;
		sdcs_wr_t wr;
	} sdcs_state_t;

endpackage

// *** sdcs_cmd_decode.sv ***
`timescale 1ns/1ps
module sdcs_cmd_decode (
	// command strobes
	input wire sdcs_pkg::sdcs_pins_t pins,
	// decoded command
	output sdcs_pkg::sdcs_cmd_t cmd
);

	// chip select high masks everything; only column commands matter here
	always_comb begin
		if (pins.chipSelN) begin
			cmd = sdcs_pkg::CMD_INHIBIT;
		end else begin
			case ({pins.rowStrobeN, pins.colStrobeN, pins.writeEnN})
				3'h7: begin
					cmd = sdcs_pkg::CMD_NOP;
				end
				3'h5: begin
					cmd = sdcs_pkg::CMD_READ;
				end
				3'h4: begin
					cmd = sdcs_pkg::CMD_WRITE;
				end
				default: begin
					cmd = sdcs_pkg::CMD_OTHER;
				end
			endcase
		end
	end

endmodule

// *** sdcs_clock_suspend.sv ***
`timescale 1ns/1ps
// How it works
// - cke registered low during a column access or burst enters suspend
// - suspended edges freeze bursts, latency pipeline and read data; cke sample, mode and hold flag still update
// - each low cke sample suppresses exactly the following internal clock edge
// - commands, addresses and write data at a suspended edge are ignored
// - read data already on the data pins stays driven and unchanged
// - burst column counter does not advance on suspended edges
// - controller ends suspend by getting cke high registered on a rising edge
// - after cke registers high, internal clocking resumes on the next edge
// - cke low with nop or inhibit and no access enters power-down instead
module sdcs_clock_suspend #(
	parameter int BURST_LEN = sdcs_pkg::BL_DEFAULT,
	parameter int CAS_LAT = sdcs_pkg::CL_DEFAULT
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// command side
	input wire logic cke,
	input wire sdcs_pkg::sdcs_pins_t pins,
	input wire logic [sdcs_pkg::COL_W-1:0] colAddr,
	// data pins
	input wire logic [sdcs_pkg::DQ_W-1:0] dqIn,
	output logic [sdcs_pkg::DQ_W-1:0] dqOut,
	output logic dqOe,
	// storage array
	input wire logic [sdcs_pkg::DQ_W-1:0] arrRdData,
	output logic [sdcs_pkg::COL_W-1:0] arrRdCol,
	output sdcs_pkg::sdcs_wr_t arrWr,
	// status
	output sdcs_pkg::sdcs_mode_t mode,
	output logic clkHeld
);

	// refuse settings the pipeline cannot hold; caught at elaboration, never in a run
	if (BURST_LEN < 1 || BURST_LEN > sdcs_pkg::MAX_BL) begin : g_bad_burst
		$error("burst length out of range");
	end

	// the latency pipeline has MAX_CL slots and the tap sits CAS_LAT-2 deep
	if (CAS_LAT < 2 || CAS_LAT > sdcs_pkg::MAX_CL) begin : g_bad_latency
		$error("read latency out of range");
	end

	// the beat counter must hold the beats that follow the first one
	if (BURST_LEN > (1 << sdcs_pkg::BEAT_W)) begin : g_bad_beat_width
		$error("beat counter too narrow for burst length");
	end

	localparam int TAP = CAS_LAT - 2;
	localparam logic [sdcs_pkg::BEAT_W-1:0] BEATS_AFTER_FIRST = sdcs_pkg::BEAT_W'(BURST_LEN - 1);

	sdcs_pkg::sdcs_state_t st;
	sdcs_pkg::sdcs_state_t next_st;
	sdcs_pkg::sdcs_cmd_t cmd;
	logic intEdge;
	logic busyNow;
	logic busyAfter;
	logic idleCmd;

	// decoded command flags and per-slot read occupancy
	logic cmdRead;
	logic cmdWrite;
	logic [sdcs_pkg::MAX_CL-1:0] pipeLive;

	sdcs_cmd_decode u_decode (
		.pins(pins),
		.cmd(cmd)
	);

	// the internal edge runs only if the previous edge saw cke high
	assign intEdge = st.ckeSample && (st.mode != sdcs_pkg::MODE_POWERDOWN);
	assign idleCmd = (cmd == sdcs_pkg::CMD_NOP) || (cmd == sdcs_pkg::CMD_INHIBIT);

	// read and write are the only commands that start a burst here
	assign cmdRead = (cmd == sdcs_pkg::CMD_READ);
	assign cmdWrite = (cmd == sdcs_pkg::CMD_WRITE);

	// one flag per latency slot that still carries a read beat
	for (genvar g = 0; g < sdcs_pkg::MAX_CL; g++) begin : g_pipe_live
		assign pipeLive[g] = st.pipe[g].valid;
	end

	// an access is in progress while a burst runs, data is in flight or on the pins;
	// a beat still in the pipeline counts, otherwise cke low there would power down
	// and drop read data the controller is still waiting for
	assign busyNow = st.burstActive || st.dqOe || (|pipeLive);

	// next state
	always_comb begin
		next_st = st;
		next_st.wr.en = 1'h0;
		// cke itself is sampled on every edge, suspended or not
		next_st.ckeSample = cke;

		if (intEdge) begin
			// latency pipeline and output register advance together
			if (st.pipe[TAP].valid) begin
				next_st.dqOut = arrRdData;
			end
			next_st.dqOe = st.pipe[TAP].valid;
			for (int i = sdcs_pkg::MAX_CL - 1; i > 0; i--) begin
				next_st.pipe[i] = st.pipe[i-1];
			end
			next_st.pipe[0].valid = 1'h0;

			// burst engine, one column per live internal edge;
			// a new column command always wins over the burst in progress
			if (cmdRead || cmdWrite) begin
				next_st.burstWrite = cmdWrite;
				next_st.burstActive = (BURST_LEN > 1);
				next_st.beatsLeft = BEATS_AFTER_FIRST;
				next_st.burstCol = colAddr + sdcs_pkg::COL_STEP;
				// the first beat uses the command's own column, later beats the counter
				if (cmdRead) begin
					next_st.pipe[0].valid = 1'h1;
					next_st.pipe[0].col = colAddr;
				end else begin
					// a write cuts off any read still in flight
					for (int i = 0; i < sdcs_pkg::MAX_CL; i++) begin
						next_st.pipe[i].valid = 1'h0;
					end
					next_st.dqOe = 1'h0;
					next_st.wr.en = 1'h1;
					next_st.wr.col = colAddr;
					next_st.wr.data = dqIn;
				end
			end else if (st.burstActive) begin
				// columns simply count up; wrap inside a burst boundary is not modelled
				next_st.burstCol = st.burstCol + sdcs_pkg::COL_STEP;
				next_st.beatsLeft = st.beatsLeft - sdcs_pkg::BEAT_ONE;
				next_st.burstActive = (st.beatsLeft != sdcs_pkg::BEAT_ONE);
				if (st.burstWrite) begin
					next_st.wr.en = 1'h1;
					next_st.wr.col = st.burstCol;
					next_st.wr.data = dqIn;
				end else begin
					next_st.pipe[0].valid = 1'h1;
					next_st.pipe[0].col = st.burstCol;
				end
			end
		end
		// on a suspended edge nothing above runs: inputs are dropped and the
		// pipeline, burst counter and driven data all hold

		// access still in progress once this edge has been applied
		busyAfter = next_st.burstActive || next_st.dqOe;
		for (int i = 0; i < sdcs_pkg::MAX_CL; i++) begin
			busyAfter = busyAfter || next_st.pipe[i].valid;
		end

		// mode follows the registered cke level; an access in progress picks
		// suspend, an idle device with a nop or inhibit picks power-down,
		// anything else keeps running (the held edge still comes from ckeSample)
		case (st.mode)
			sdcs_pkg::MODE_POWERDOWN: begin
				// leave only with cke high and a nop or inhibit on the pins
				if (cke && idleCmd) begin
					next_st.mode = sdcs_pkg::MODE_RUN;
				end
			end
			sdcs_pkg::MODE_RUN, sdcs_pkg::MODE_SUSPEND: begin
				if (!cke && busyAfter) begin
					next_st.mode = sdcs_pkg::MODE_SUSPEND;
				end else if (!cke && idleCmd && !busyNow) begin
					next_st.mode = sdcs_pkg::MODE_POWERDOWN;
					next_st.dqOe = 1'h0;
				end else begin
					// run mode; the next edge clocks again only if cke registered high here
					next_st.mode = sdcs_pkg::MODE_RUN;
				end
			end
			default: begin
				next_st.mode = sdcs_pkg::MODE_RUN;
			end
		endcase

		// flags whether the coming edge will be swallowed; registered so the
		// controller sees it one cycle ahead of the frozen edge
		next_st.clkHeld = !next_st.ckeSample || (next_st.mode == sdcs_pkg::MODE_POWERDOWN);
	end

	// state register; reset leaves the internal clock held until cke is seen high
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st.mode <= sdcs_pkg::MODE_RUN;
			st.ckeSample <= sdcs_pkg::CKE_RESET;
			// nothing in flight and the data pins released after reset
			st.clkHeld <= sdcs_pkg::HELD_RESET;
			st.burstActive <= 1'h0;
			st.burstWrite <= 1'h0;
			st.burstCol <= sdcs_pkg::COL_RESET;
			st.beatsLeft <= sdcs_pkg::BEAT_RESET;
			st.pipe <= '0;
			st.dqOut <= sdcs_pkg::DQ_RESET;
			st.dqOe <= 1'h0;
			st.wr <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign dqOut = st.dqOut;
	assign dqOe = st.dqOe;
	assign arrRdCol = st.pipe[TAP].col; // array read is combinational on this column
	assign arrWr = st.wr;
	assign mode = st.mode;
	assign clkHeld = st.clkHeld;

endmodule

// *** sdcs_array_model.sv ***
`timescale 1ns/1ps
module sdcs_array_model (
	// column asked for and data returned
	input wire logic [9:0] arrRdCol,
	output logic [15:0] arrRdData
);
	// data carries its own column, so a slipped beat shows at once
	assign arrRdData = {6'h2a, arrRdCol};
endmodule

// *** sdcs_clock_suspend_chk.sv ***
`timescale 1ns/1ps
module sdcs_clock_suspend_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// command side
	input wire logic cke,
	input wire sdcs_pkg::sdcs_pins_t pins,
	input wire logic [sdcs_pkg::COL_W-1:0] colAddr,
	input wire logic [sdcs_pkg::DQ_W-1:0] dqIn,
	// outputs
	input wire logic [sdcs_pkg::DQ_W-1:0] dqOut,
	input wire logic dqOe,
	input wire logic [sdcs_pkg::COL_W-1:0] arrRdCol,
	input wire sdcs_pkg::sdcs_wr_t arrWr,
	input wire sdcs_pkg::sdcs_mode_t mode,
	input wire logic clkHeld
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// a command on an edge that is not frozen
	sequence s_live(p);
		!clkHeld && mode != sdcs_pkg::MODE_POWERDOWN && pins == p;
	endsequence
	a_held_tracks: assert property (mode != sdcs_pkg::MODE_POWERDOWN |-> clkHeld == !$past(cke))
		else $error("hold flag does not follow cke");
	a_read_tap: assert property (s_live(4'h5) |=> arrRdCol == $past(colAddr))
		else $error("read column not taken");
	a_write_beat: assert property (s_live(4'h4)
		|=> arrWr.en && arrWr.col == $past(colAddr) && arrWr.data == $past(dqIn))
		else $error("write beat wrong");
	a_frozen_out: assert property (clkHeld && mode != sdcs_pkg::MODE_POWERDOWN
		|=> $stable({dqOut, dqOe, arrRdCol}))
		else $error("output moved on frozen edge");
	a_frozen_write: assert property (clkHeld |=> !arrWr.en)
		else $error("write on frozen edge");
	a_enter_susp: assert property (dqOe && !cke |=> mode == sdcs_pkg::MODE_SUSPEND && clkHeld)
		else $error("suspend not entered");
	a_leave_susp: assert property (mode == sdcs_pkg::MODE_SUSPEND && cke |=> !clkHeld)
		else $error("suspend not left");
	a_pd_quiet: assert property (mode == sdcs_pkg::MODE_POWERDOWN |-> !dqOe)
		else $error("data driven in power-down");
endmodule
bind sdcs_clock_suspend sdcs_clock_suspend_chk u_chk (.sys_clk, .sys_rst, .cke, .pins, .colAddr, .dqIn,
	.dqOut, .dqOe, .arrRdCol, .arrWr, .mode, .clkHeld);

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin \
	comparisons++; \
	if ((a) !== (e)) begin \
		err_total++; \
		$display("Error %0t: got %h exp %h", $time, (a), (e)); \
	end \
end
module tb_top;
	localparam int BL = 4;
	// design pins and model state
	logic sys_clk = 0, sys_rst = 1, cke = 0, dqOe, clkHeld, ckeQ = 0;
	sdcs_pkg::sdcs_pins_t pins = 4'h7;
	logic [9:0] colAddr = '0, arrRdCol, a, wc;
	logic [15:0] dqIn = '0, dqOut, arrRdData;
	sdcs_pkg::sdcs_wr_t arrWr;
	sdcs_pkg::sdcs_mode_t mode;
	int seed = 70, err_total = 0, comparisons = 0, wl = 0;
	logic [15:0] rq[$];
	logic [25:0] wq[$];
	sdcs_clock_suspend #(.BURST_LEN(BL), .CAS_LAT(2)) dut (.sys_clk, .sys_rst, .cke, .pins, .colAddr, .dqIn,
		.dqOut, .dqOe, .arrRdData, .arrRdCol, .arrWr, .mode, .clkHeld);
	sdcs_array_model mem (.arrRdCol, .arrRdData);
	// 100 ns clock
	initial forever #50 sys_clk = ~sys_clk;
	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one clock; with k high cke only drops while more than one beat is left, else power-down would hit
	task automatic tick(input logic [3:0] p, input logic [9:0] c, input logic k);
		logic live;
		live = ckeQ;
		if (!live && mode != sdcs_pkg::MODE_POWERDOWN) p = 4'h5;
		pins = p;
		colAddr = c;
		dqIn = 16'($random(seed));
		cke = k && ((wl > 1 || rq.size() > 1) ? 1'($random(seed)) : 1'b1);
		@(posedge sys_clk);
		#1;
		ckeQ = cke;
		if (live && p == 4'h4) begin
			wl = BL;
			wc = c;
		end
		if (live && p == 4'h5)
			for (int i = 0; i < BL; i++) rq.push_back({6'h2a, c + 10'(i)});
		if (live && wl > 0) begin
			wq.push_back({wc, dqIn});
			wc++;
			wl--;
		end
		if (live && dqOe === 1'b1) `CHK(dqOut, rq.pop_front())
		if (arrWr.en === 1'b1) `CHK({arrWr.col, arrWr.data}, wq.pop_front())
		`CHK(clkHeld, !ckeQ)
	endtask
	// run until the model has no beats left, bounded
	task automatic drain();
		int i;
		for (i = 0; i < 50 && (wl > 0 || rq.size() > 0); i++) tick(4'h7, '0, 1'b1);
		if (i == 50) begin
			err_total++;
			$display("Error %0t: burst never ended", $time);
			end_of_test();
		end
		tick(4'h7, '0, 1'b1);
		tick(4'h7, '0, 1'b1);
	endtask
	// reset, suspended bursts, then power-down entry and exit
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 sys_rst = 0;
		tick(4'h7, '0, 1'b1);
		tick(4'h7, '0, 1'b1);
		for (int n = 0; n < 8; n++) begin
			a = 10'($random(seed)) & 10'h3f0;
			tick(4'h4, a, 1'b1);
			drain();
			tick(4'h5, a, 1'b1);
			drain();
			$display("test %0d done", n);
		end
		tick(4'h7, '0, 1'b0);
		`CHK(mode, sdcs_pkg::MODE_POWERDOWN)
		tick(4'h7, '0, 1'b1);
		tick(4'h7, '0, 1'b1);
		`CHK(mode, sdcs_pkg::MODE_RUN)
		$display("test power-down done");
		end_of_test();
	end
endmodule
